// File: verilog/halfword_load_store_and_unit.sv
// Purpose: Executes the halfword AND and fixed-point load/store instruction group
// Assumes: One clock; memory answers each request with a one-cycle mem_ack
// Notes:   Status word and general registers are visible over the register port
`include "hlsa_cfg.svh"
`default_nettype none
module halfword_load_store_and_unit #(
  parameter int NREGS = 16
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  // Instruction issue from the core
  input  wire logic                  instr_valid,
  input  wire logic [31:0]           instr_word,
  output logic                       instr_ready,
  output logic                       instr_done,
  output logic                       prot_violation,
  output logic                       illegal_op,
  // Core memory side
  output hlsa_pkg::mem_req_t         mem_out,
  input  wire logic                  mem_ack,
  input  wire logic [15:0]           mem_rdata,
  // Register port
  input  wire hlsa_pkg::reg_req_t    reg_in,
  output logic [31:0]                reg_rdata
);

  // Whole state of the unit
  typedef struct packed {
    hlsa_pkg::exec_state_t   st;        // Execution phase
    hlsa_pkg::instr_fields_t ins;       // Latched instruction
    logic [3:0]              cur;       // Register under transfer
    logic [15:0]             addr;      // Running memory address
    logic                    cc_upd;    // Finish writes a new condition code
    logic [15:0]             cc_val;    // Result that drives the new code
    logic                    viol;      // Finish reports a protect violation
    logic                    illegal;   // Finish reports an unknown opcode
    hlsa_pkg::mem_req_t      mem;       // Memory request, one-cycle strobe
    logic                    done;      // Completion pulse
    logic                    viol_p;    // Violation pulse
    logic                    ill_p;     // Illegal pulse
    logic [31:0]             program_status_word;       // Program status word
    logic [15:0]             prot_lim;  // Addresses below this are protected
    logic                    viol_seen; // Sticky violation flag
    logic                    ill_seen;  // Sticky illegal flag
    logic [31:0]             rdata;     // Register port read data
  } unit_state_t;

  unit_state_t s_reg;   // Registered state
  unit_state_t s_next;  // Next state

  // Register bank wiring
  logic        gpr_we;      // Bank write enable
  logic [3:0]  gpr_waddr;   // Bank write address
  logic [15:0] gpr_wdata;   // Bank write data
  logic [3:0]  gpr_raddr_b; // Index, second register or next run register
  logic [15:0] r1_val;      // Contents of register under R1 or run pointer
  logic [15:0] rb_val;      // Contents on port b
  logic [15:0] dbg_val;     // Register window read for software

  // Combinational helpers
  logic [15:0] index_val;   // Index contents, zero for field 0
  logic [15:0] eff_addr;    // Address field plus index
  logic [15:0] short_imm;   // Zero-extended short immediate
  logic        in_gpr_win;  // Register port addresses the register window
  logic [3:0]  cur_plus;    // Next run register

  // Condition code from a 16-bit result: carry and overflow read as zero
  function automatic logic [3:0] cc_of(input logic [15:0] v);
    logic [3:0] c;
    c    = 4'h0;
    c[1] = (v != 16'h0000) && !v[15];
    c[0] = v[15];
    return c;
  endfunction

  gpr_bank #(
    .WIDTH (16),
    .COUNT (NREGS)
  ) u_gpr (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .we      (gpr_we),
    .waddr   (gpr_waddr),
    .wdata   (gpr_wdata),
    .raddr_a ((s_reg.st == hlsa_pkg::ST_EXEC) ? s_reg.ins.r1 : s_reg.cur),
    .raddr_b (gpr_raddr_b),
    .raddr_c (reg_in.addr[5:2]),
    .rdata_a (r1_val),
    .rdata_b (rb_val),
    .rdata_c (dbg_val)
  );

  // Port b address stays out of the operand block, so no loop runs through the bank
  assign cur_plus    = s_reg.cur + 4'h1;
  assign gpr_raddr_b = (s_reg.st == hlsa_pkg::ST_WR_WAIT) ? cur_plus : s_reg.ins.r2;

  // Operand formation shared by every phase
  always_comb begin
    index_val   = (s_reg.ins.r2 == 4'h0) ? 16'h0000 : rb_val;
    eff_addr    = s_reg.ins.a + index_val;
    short_imm   = {12'h000, s_reg.ins.r2};
    in_gpr_win  = (reg_in.addr & `OFF_GPR_MASK) == `OFF_GPR_BASE;
  end

  // Next-state logic
  always_comb begin
    s_next        = s_reg;
    s_next.mem.req = 1'b0;       // Memory strobe lasts one cycle
    s_next.done   = 1'b0;
    s_next.viol_p = 1'b0;
    s_next.ill_p  = 1'b0;
    gpr_we        = 1'b0;
    gpr_waddr     = s_reg.ins.r1;
    gpr_wdata     = 16'h0000;

    // Register port: reads answer next cycle, unmapped reads give zero
    if (reg_in.rd) begin
      if (reg_in.addr == `OFF_PSW) begin
        s_next.rdata = s_reg.program_status_word;
      end else if (reg_in.addr == `OFF_STATUS) begin
        s_next.rdata = {29'h0, s_reg.ill_seen, s_reg.viol_seen,
                        (s_reg.st != hlsa_pkg::ST_IDLE)};
      end else if (reg_in.addr == `OFF_PROTECT) begin
        s_next.rdata = {16'h0000, s_reg.prot_lim};
      end else if (in_gpr_win) begin
        s_next.rdata = {16'h0000, dbg_val};
      end else begin
        s_next.rdata = 32'h0000_0000;
      end
    end
    if (reg_in.wr) begin
      if (reg_in.addr == `OFF_PSW) begin
        s_next.program_status_word = reg_in.wdata;
      end else if (reg_in.addr == `OFF_PROTECT) begin
        s_next.prot_lim = reg_in.wdata[15:0];
      end else if (reg_in.addr == `OFF_STATUS) begin
        // Write one to clear; a same-cycle event sets it again below
        if (reg_in.wdata[`STATUS_VIOL_BIT]) begin
          s_next.viol_seen = 1'b0;
        end
        if (reg_in.wdata[`STATUS_ILLEGAL_BIT]) begin
          s_next.ill_seen = 1'b0;
        end
      end else if (in_gpr_win && (s_reg.st == hlsa_pkg::ST_IDLE)) begin
        // Software loads registers only while no instruction runs
        gpr_we    = 1'b1;
        gpr_waddr = reg_in.addr[5:2];
        gpr_wdata = reg_in.wdata[15:0];
      end
    end

    case (s_reg.st)
      hlsa_pkg::ST_IDLE: begin
        // Accept a new instruction
        if (instr_valid) begin
          s_next.ins     = instr_word;
          s_next.cc_upd  = 1'b0;
          s_next.viol    = 1'b0;
          s_next.illegal = 1'b0;
          s_next.st      = hlsa_pkg::ST_EXEC;
        end
      end
      hlsa_pkg::ST_EXEC: begin
        // Register forms finish here; memory forms start a request, except a store below the protect limit
        s_next.st     = hlsa_pkg::ST_FINISH;
        s_next.cc_upd = 1'b1;
        gpr_waddr     = s_reg.ins.r1;
        case (s_reg.ins.op)
          `OP_AND_REG_REG: begin
            gpr_we    = 1'b1;
            gpr_wdata = r1_val & rb_val;
          end
          `OP_AND_IMMEDIATE_INDEXED: begin
            gpr_we    = 1'b1;
            gpr_wdata = r1_val & eff_addr;
          end
          `OP_LOAD_SHORT_IMMEDIATE: begin
            gpr_we    = 1'b1;
            gpr_wdata = short_imm;
          end
          `OP_LOAD_NEGATED_SHORT: begin
            gpr_we    = 1'b1;
            gpr_wdata = 16'h0000 - short_imm;
          end
          `OP_COPY_REG_REG: begin
            gpr_we    = 1'b1;
            gpr_wdata = rb_val;
          end
          `OP_LOAD_IMMEDIATE_INDEXED: begin
            gpr_we    = 1'b1;
            gpr_wdata = eff_addr;
          end
          `OP_AND_INDEXED_MEMORY, `OP_LOAD_MEMORY_WORD, `OP_LOAD_REGISTER_RUN: begin
            // Fetch the operand halfword at the effective address
            s_next.cc_upd   = 1'b0;
            s_next.cur      = s_reg.ins.r1;
            s_next.addr     = eff_addr;
            s_next.mem.req  = 1'b1;
            s_next.mem.we   = 1'b0;
            s_next.mem.addr = eff_addr;
            s_next.st       = hlsa_pkg::ST_RD_WAIT;
          end
          `OP_STORE_MEMORY_WORD, `OP_STORE_REGISTER_RUN: begin
            // Stores leave the condition code alone
            s_next.cc_upd = 1'b0;
            s_next.cur    = s_reg.ins.r1;
            s_next.addr   = eff_addr;
            if (eff_addr < s_reg.prot_lim) begin
              s_next.viol = 1'b1;
            end else begin
              s_next.mem.req   = 1'b1;
              s_next.mem.we    = 1'b1;
              s_next.mem.addr  = eff_addr;
              s_next.mem.wdata = r1_val;
              s_next.st        = hlsa_pkg::ST_WR_WAIT;
            end
          end
          default: begin
            // Unknown opcode: report and leave registers and condition code alone
            s_next.cc_upd  = 1'b0;
            s_next.illegal = 1'b1;
          end
        endcase
      end
      hlsa_pkg::ST_RD_WAIT: begin
        // Wait for the memory answer, then use it
        if (mem_ack) begin
          if (s_reg.ins.op == `OP_LOAD_REGISTER_RUN) begin
            gpr_we    = 1'b1;
            gpr_waddr = s_reg.cur;
            gpr_wdata = mem_rdata;
            if (s_reg.cur == `LAST_REG) begin
              s_next.st = hlsa_pkg::ST_FINISH;
            end else begin
              s_next.cur      = cur_plus;
              s_next.addr     = s_reg.addr + `HALFWORD_STEP;
              s_next.mem.req  = 1'b1;
              s_next.mem.addr = s_reg.addr + `HALFWORD_STEP;
            end
          end else begin
            gpr_we        = 1'b1;
            gpr_waddr     = s_reg.ins.r1;
            s_next.cc_upd = 1'b1;
            s_next.st     = hlsa_pkg::ST_FINISH;
            if (s_reg.ins.op == `OP_AND_INDEXED_MEMORY) begin
              gpr_wdata = r1_val & mem_rdata;
            end else begin
              gpr_wdata = mem_rdata;
            end
          end
        end
      end
      hlsa_pkg::ST_WR_WAIT: begin
        // Wait for the write to land; a run moves to the next register
        if (mem_ack) begin
          if ((s_reg.ins.op != `OP_STORE_REGISTER_RUN) || (s_reg.cur == `LAST_REG)) begin
            s_next.st = hlsa_pkg::ST_FINISH;
          end else if ((s_reg.addr + `HALFWORD_STEP) < s_reg.prot_lim) begin
            s_next.viol = 1'b1;
            s_next.st   = hlsa_pkg::ST_FINISH;
          end else begin
            s_next.cur       = cur_plus;
            s_next.addr      = s_reg.addr + `HALFWORD_STEP;
            s_next.mem.req   = 1'b1;
            s_next.mem.we    = 1'b1;
            s_next.mem.addr  = s_reg.addr + `HALFWORD_STEP;
            s_next.mem.wdata = rb_val;
          end
        end
      end
      hlsa_pkg::ST_FINISH: begin
        // Report completion and advance the instruction address
        s_next.done   = 1'b1;
        s_next.viol_p = s_reg.viol;
        s_next.ill_p  = s_reg.illegal;
        if (s_reg.ins.op < `OP_LONG_FORMAT_MIN) begin
          s_next.program_status_word[`PSW_IA_MSB:`PSW_IA_LSB] = s_reg.program_status_word[`PSW_IA_MSB:`PSW_IA_LSB] + `LEN_SHORT;
        end else begin
          s_next.program_status_word[`PSW_IA_MSB:`PSW_IA_LSB] = s_reg.program_status_word[`PSW_IA_MSB:`PSW_IA_LSB] + `LEN_LONG;
        end
        if (s_reg.cc_upd) begin
          // All four bits are rewritten; hardware beats a same-cycle write
          s_next.program_status_word[`PSW_CC_MSB:`PSW_CC_LSB] = cc_of(s_reg.cc_val);
        end
        // Sticky flags: a new event wins over a clear
        if (s_reg.viol) begin
          s_next.viol_seen = 1'b1;
        end
        if (s_reg.illegal) begin
          s_next.ill_seen = 1'b1;
        end
        s_next.st = hlsa_pkg::ST_IDLE;
      end
      default: begin
        s_next.st = hlsa_pkg::ST_IDLE;
      end
    endcase

    // Remember the value written to R1 for the condition code
    if (gpr_we && (s_reg.st != hlsa_pkg::ST_IDLE)) begin
      s_next.cc_val = gpr_wdata;
    end
  end

  // State register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg          <= '0;
      s_reg.st       <= hlsa_pkg::ST_IDLE;
      s_reg.program_status_word      <= `PSW_RESET;
      s_reg.prot_lim <= `PROTECT_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flops
  assign instr_ready    = s_reg.st[0];  // One-hot idle bit, a flop of its own
  assign instr_done     = s_reg.done;
  assign prot_violation = s_reg.viol_p;
  assign illegal_op     = s_reg.ill_p;
  assign mem_out        = s_reg.mem;
  assign reg_rdata      = s_reg.rdata;

endmodule
`default_nettype wire

// File: verilog/hlsa_cfg.svh
// Purpose: Offsets, field positions, opcodes and reset values of the halfword unit
// Assumes: Included by bare name from every design file that needs it
// Notes:   Definitions only
`ifndef HLSA_CFG_SVH
`define HLSA_CFG_SVH

// Opcodes of the AND and load/store group
`define OP_AND_REG_REG            8'h04
`define OP_AND_INDEXED_MEMORY     8'h44
`define OP_AND_IMMEDIATE_INDEXED  8'hC4
`define OP_LOAD_SHORT_IMMEDIATE   8'h24
`define OP_LOAD_NEGATED_SHORT     8'h25
`define OP_COPY_REG_REG           8'h08
`define OP_LOAD_MEMORY_WORD       8'h48
`define OP_LOAD_IMMEDIATE_INDEXED 8'hC8
`define OP_LOAD_REGISTER_RUN      8'hD1
`define OP_STORE_MEMORY_WORD      8'h40
`define OP_STORE_REGISTER_RUN     8'hD0
// Opcodes at or above this value carry the 16-bit address field
`define OP_LONG_FORMAT_MIN        8'h40

// Instruction word, left justified: bit 0 of the word is bit 31 here
`define INSTR_OP_MSB              31
`define INSTR_OP_LSB              24
`define INSTR_R1_MSB              23
`define INSTR_R1_LSB              20
`define INSTR_R2_MSB              19
`define INSTR_R2_LSB              16
`define INSTR_A_MSB               15
`define INSTR_A_LSB               0

// Status word: carry, overflow, greater, less sit at word bits 12..15
`define PSW_CARRY_BIT             19
`define PSW_OVFL_BIT              18
`define PSW_GREATER_BIT           17
`define PSW_LESS_BIT              16
`define PSW_CC_MSB                19
`define PSW_CC_LSB                16
`define PSW_IA_MSB                15
`define PSW_IA_LSB                0
`define PSW_RESET                 32'h0000_0000

// Instruction lengths and the step between halfwords in bytes
`define LEN_SHORT                 16'h0002
`define LEN_LONG                  16'h0004
`define HALFWORD_STEP             16'h0002
`define LAST_REG                  4'hF

// Register port byte offsets
`define OFF_PSW                   8'h00
`define OFF_STATUS                8'h04
`define OFF_PROTECT               8'h08
`define OFF_GPR_BASE              8'h40
`define OFF_GPR_MASK              8'hC0
`define STATUS_BUSY_BIT           0
`define STATUS_VIOL_BIT           1
`define STATUS_ILLEGAL_BIT        2
`define PROTECT_RESET             16'h0000

`endif

// File: verilog/hlsa_pkg.sv
// Purpose: Types shared by the halfword unit, its memory model, assertions and bench
// Assumes: Constants live in hlsa_cfg.svh
// Notes:   Nothing is imported; users write hlsa_pkg::name
`default_nettype none
package hlsa_pkg;

  // One-hot execution states
  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_EXEC    = 5'b00010,
    ST_RD_WAIT = 5'b00100,
    ST_WR_WAIT = 5'b01000,
    ST_FINISH  = 5'b10000
  } exec_state_t;

  // Decoded instruction fields
  typedef struct packed {
    logic [7:0]  op;
    logic [3:0]  r1;
    logic [3:0]  r2;   // Second register, index register or short immediate
    logic [15:0] a;
  } instr_fields_t;

  // Request towards core memory
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_t;

endpackage
`default_nettype wire

// File: verilog/gpr_bank.sv
// Purpose: Sixteen general registers with three read ports and one write port
// Assumes: Single clock, asynchronous active-high reset
// Notes:   Reads are combinational; a write lands at the next edge
`default_nettype none
module gpr_bank #(
  parameter int WIDTH = 16,
  parameter int COUNT = 16
) (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  // Write port
  input  wire logic                     we,
  input  wire logic [$clog2(COUNT)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  // Read ports
  input  wire logic [$clog2(COUNT)-1:0] raddr_a,
  input  wire logic [$clog2(COUNT)-1:0] raddr_b,
  input  wire logic [$clog2(COUNT)-1:0] raddr_c,
  output logic      [WIDTH-1:0]         rdata_a,
  output logic      [WIDTH-1:0]         rdata_b,
  output logic      [WIDTH-1:0]         rdata_c
);

  localparam int AW = $clog2(COUNT);  // Register address width

  logic [WIDTH-1:0] regs [COUNT];  // Register storage

  // One flop group per register, each loads only when addressed
  for (genvar i = 0; i < COUNT; i++) begin : g_reg
    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
        regs[i] <= '0;
      end else if (we && (waddr == AW'(i))) begin
        regs[i] <= wdata;
      end
    end
  end

  // Combinational read ports
  assign rdata_a = regs[raddr_a];
  assign rdata_b = regs[raddr_b];
  assign rdata_c = regs[raddr_c];

endmodule
`default_nettype wire

// File: verification/hlsa_asserts.sv
// Purpose: Port-level assertions for the halfword AND and load/store unit
// Assumes: One clock, asynchronous active-high reset, bound to the top module
// Notes:   Helper flops remember the running opcode and the last memory address
`default_nettype none
module hlsa_asserts #(
  parameter int NREGS = 16
) (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               sys_rst,
  // Instruction side
  input wire logic               instr_valid,
  input wire logic [31:0]        instr_word,
  input wire logic               instr_ready,
  input wire logic               instr_done,
  input wire logic               prot_violation,
  input wire logic               illegal_op,
  // Memory side
  input wire hlsa_pkg::mem_req_t mem_out,
  input wire logic               mem_ack,
  input wire logic [15:0]        mem_rdata,
  // Register port
  input wire hlsa_pkg::reg_req_t reg_in,
  input wire logic [31:0]        reg_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  logic [7:0]  op_reg;    // Opcode of the instruction in flight
  logic [15:0] addr_reg;  // Address of the previous request in this instruction
  logic        run_reg;   // A request was already made in this instruction

  // Track the opcode and the last request; done closes the instruction
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      op_reg   <= 8'h00;
      addr_reg <= 16'h0000;
      run_reg  <= 1'b0;
    end else begin
      if (instr_valid && instr_ready) op_reg <= instr_word[31:24];
      if (instr_done) run_reg <= 1'b0;
      else if (mem_out.req) begin
        run_reg  <= 1'b1;
        addr_reg <= mem_out.addr;
      end
    end
  end

  sequence take_s;
    instr_valid && instr_ready;
  endsequence
  sequence short_take_s;
    take_s ##0 (instr_word[31:24] < 8'h40);
  endsequence

  short_done_a: assert property (short_take_s |=> !instr_done [*2] ##1 instr_done)
    else $error("register-only op did not finish in three cycles");
  short_nomem_a: assert property (short_take_s |=> !mem_out.req [*3])
    else $error("register-only op touched memory");
  load_req_a: assert property (take_s ##0 instr_word[31:24] == 8'h48 |->
    ##2 (mem_out.req && !mem_out.we)) else $error("memory load request missing");
  mem_done_a: assert property (mem_ack && (op_reg == 8'h48 || op_reg == 8'h40
    || op_reg == 8'h44) |-> ##2 instr_done) else $error("single access did not finish");
  addr_step_a: assert property (mem_out.req && run_reg |->
    mem_out.addr == addr_reg + 16'h0002) else $error("run address did not step by two");
  viol_done_a: assert property (prot_violation |-> instr_done && !mem_out.req)
    else $error("violation without completion");
  run_write_a: assert property (mem_out.req && op_reg == 8'hD0 |-> mem_out.we)
    else $error("store run issued a read");
  run_read_a: assert property (mem_out.req && op_reg == 8'hD1 |-> !mem_out.we)
    else $error("load run issued a write");
endmodule
bind halfword_load_store_and_unit hlsa_asserts #(.NREGS(NREGS)) u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_word(instr_word),
  .instr_ready(instr_ready), .instr_done(instr_done), .prot_violation(prot_violation),
  .illegal_op(illegal_op), .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
  .reg_in(reg_in), .reg_rdata(reg_rdata));
`default_nettype wire

// File: verification/halfword_memory_model.sv
// Purpose: Core memory behind the unit, answering each request with one ack
// Assumes: Halfword addressed; only 512 bytes are modelled
// Notes:   Slow mode adds three wait cycles before the ack
`default_nettype none
module halfword_memory_model (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               sys_rst,
  // Request and answer
  input wire hlsa_pkg::mem_req_t mem_out,
  input wire logic               slow,
  output var logic               mem_ack,
  output var logic [15:0]        mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:255];  // Storage, index is address bits 8:1
  logic [15:0] last;         // Last data driven, inverted when idle
  logic        pend;         // Request waiting for its ack
  int          cnt;          // Wait cycles left

  initial for (int i = 0; i < 256; i++) mem[i] = 16'h0000;

  // Idle data is the inverse of the last value so stale reads never match
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pend <= 1'b0;
      mem_ack <= 1'b0;
      mem_rdata <= 16'hFFFF;
      last <= 16'h0000;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~last;
      if (mem_out.req) begin
        pend <= 1'b1;
        cnt <= slow ? 3 : 0;
      end else if (pend && cnt > 0) cnt <= cnt - 1;
      else if (pend) begin
        pend <= 1'b0;
        mem_ack <= 1'b1;
        if (mem_out.we) mem[mem_out.addr[8:1]] <= mem_out.wdata;
        else begin
          mem_rdata <= mem[mem_out.addr[8:1]];
          last <= mem[mem_out.addr[8:1]];
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/tb.sv
// Purpose: Self-checking bench for the halfword AND and load/store unit
// Assumes: Registers reached at 0x40 plus four per register, PROGRAM_STATUS_WORD at 0x00
// Notes:   Instruction address is tracked here to predict the status word
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               mclk = 1'b0;
  logic               sys_rst = 1'b1;
  logic               instr_valid = 1'b0;
  logic [31:0]        instr_word = 32'h0000_0000;
  logic               instr_ready, instr_done, prot_violation, illegal_op;
  hlsa_pkg::mem_req_t mem_out;
  logic               mem_ack, slow = 1'b0;
  logic [15:0]        mem_rdata, ia = 16'h0000;
  hlsa_pkg::reg_req_t reg_in = '0;
  logic [31:0]        reg_rdata;
  logic               viol, ill;  // Flags seen at completion
  int                 err_count = 0, n_checks = 0, cyc = 0;

  always #10 mclk = ~mclk;

  halfword_load_store_and_unit u_dut (.mclk(mclk), .sys_rst(sys_rst),
    .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
    .instr_done(instr_done), .prot_violation(prot_violation), .illegal_op(illegal_op),
    .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .reg_in(reg_in),
    .reg_rdata(reg_rdata));
  halfword_memory_model u_mem (.mclk(mclk), .sys_rst(sys_rst), .mem_out(mem_out),
    .slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  task automatic complete_run;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe, then release
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk) reg_in <= '{1'b1, 1'b0, a, d};
    @(posedge mclk) reg_in <= '0;
  endtask

  // Read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk) reg_in <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge mclk) reg_in <= '0;
    #1 chk(reg_rdata, exp);
  endtask

  // Offer one instruction, wait for done under a bound, keep the IA model
  task automatic ex(input logic [7:0] op, input logic [3:0] r1, input logic [3:0] r2,
                    input logic [15:0] a);
    int n = 0;
    @(posedge mclk) instr_valid <= 1'b1;
    instr_word <= {op, r1, r2, a};
    @(posedge mclk) instr_valid <= 1'b0;
    do begin
      @(posedge mclk) #1 n++;
    end while (instr_done !== 1'b1 && n < 60);
    viol = prot_violation;
    ill = illegal_op;
    if (n >= 60) chk(32'h0000_0000, 32'h0000_0001);
    ia = ia + ((op >= 8'h40) ? 16'h0004 : 16'h0002);
  endtask

  task automatic program_status_word(input logic [3:0] cc);
    rd(8'h00, {12'h000, cc, ia});
  endtask

  // Hang guard: fewer than two hundred cycles are needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(8'h00, 32'h0000_0000);
    rd(8'h4C, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    // A nonzero R0 shows whether index field 0 wrongly adds an index
    wr(8'h40, 32'h0000_5555);
    rd(8'h40, 32'h0000_5555);
    ex(8'h24, 4'h3, 4'hF, 16'h0000);
    rd(8'h4C, 32'h0000_000F);
    program_status_word(4'b0010);
    ex(8'h25, 4'h4, 4'h1, 16'h0000);
    rd(8'h50, 32'h0000_FFFF);
    program_status_word(4'b0001);
    wr(8'h48, 32'h0000_00F0);
    ex(8'h08, 4'h5, 4'h2, 16'h0000);
    rd(8'h54, 32'h0000_00F0);
    ex(8'h04, 4'h3, 4'h2, 16'h0000);
    rd(8'h4C, 32'h0000_0000);
    program_status_word(4'b0000);
    ex(8'hC8, 4'h6, 4'h2, 16'h1000);
    rd(8'h58, 32'h0000_10F0);
    ex(8'hC4, 4'h4, 4'h2, 16'h0F00);
    rd(8'h50, 32'h0000_0FF0);
    // Slow memory for the store so the unit must wait on the ack
    slow <= 1'b1;
    ex(8'h40, 4'h6, 4'h0, 16'h0100);
    chk(u_mem.mem[8'h80], 32'h0000_10F0);
    rd(8'h58, 32'h0000_10F0);
    slow <= 1'b0;
    ex(8'h48, 4'h7, 4'h2, 16'h0010);
    rd(8'h5C, 32'h0000_10F0);
    ex(8'h44, 4'h4, 4'h0, 16'h0100);
    rd(8'h50, 32'h0000_00F0);
    wr(8'h78, 32'h0000_1234);
    wr(8'h7C, 32'h0000_ABCD);
    ex(8'hD0, 4'hE, 4'h0, 16'h0200);
    chk(u_mem.mem[8'h00], 32'h0000_1234);
    chk(u_mem.mem[8'h01], 32'h0000_ABCD);
    chk(u_mem.mem[8'h02], 32'h0000_0000);
    program_status_word(4'b0010);
    wr(8'h74, 32'h0000_0005);
    wr(8'h78, 32'h0000_0000);
    wr(8'h7C, 32'h0000_0000);
    ex(8'hD1, 4'hD, 4'h0, 16'h01FE);
    rd(8'h74, 32'h0000_0000);
    rd(8'h78, 32'h0000_1234);
    rd(8'h7C, 32'h0000_ABCD);
    // Protected store: nothing written, sticky flag set then cleared
    wr(8'h08, 32'h0000_0300);
    ex(8'h40, 4'h6, 4'h0, 16'h0200);
    chk({31'h0, viol}, 32'h0000_0001);
    chk(u_mem.mem[8'h00], 32'h0000_1234);
    rd(8'h04, 32'h0000_0002);
    wr(8'h04, 32'h0000_0002);
    ex(8'hFF, 4'h0, 4'h0, 16'h0000);
    chk({31'h0, ill}, 32'h0000_0001);
    rd(8'h04, 32'h0000_0004);
    program_status_word(4'b0010);
    // Software rewrites the whole status word
    wr(8'h00, 32'h1230_0100);
    rd(8'h00, 32'h1230_0100);
    complete_run();
  end
endmodule
`default_nettype wire
